// >>> tct_pkg.sv
// package for the transactional conflict tracker
// assumes a single core clock and synchronous reset
package tct_pkg;
	// instruction codes presented on the command port
	typedef enum logic [3:0] {
		TCT_OP_NONE    = 4'h0,
		TCT_OP_BEGIN   = 4'h1, // begin_transaction_instr
		TCT_OP_END     = 4'h2, // end_transaction_instr
		TCT_OP_ACQ     = 4'h3, // elide_acquire_prefix on a lock instruction
		TCT_OP_REL     = 4'h4, // elide_release_prefix on a lock instruction
		TCT_OP_TEST    = 4'h5, // transactional_status_test
		TCT_OP_ABORT   = 4'h6, // explicit_abort_instr
		TCT_OP_LOAD    = 4'h7,
		TCT_OP_STORE   = 4'h8,
		TCT_OP_FORBID  = 4'h9, // processor_identify_instr or i/o instruction
		TCT_OP_EVICT   = 4'ha  // first-level eviction of a line
	} tct_op_e;

	// tracker state
	typedef enum logic [1:0] {
		TCT_ST_IDLE   = 2'b00,
		TCT_ST_REGION = 2'b01, // begin/end region
		TCT_ST_ELIDE  = 2'b10  // prefix elision of a lock
	} tct_state_e;

	// abort cause codes
	localparam logic [2:0] TCT_CAUSE_NONE     = 3'h0;
	localparam logic [2:0] TCT_CAUSE_CONFLICT = 3'h1;
	localparam logic [2:0] TCT_CAUSE_CAPACITY = 3'h2;
	localparam logic [2:0] TCT_CAUSE_FORBID   = 3'h3;
	localparam logic [2:0] TCT_CAUSE_EXPLICIT = 3'h4;
	localparam logic [2:0] TCT_CAUSE_EVICT    = 3'h5;
	localparam logic [2:0] TCT_CAUSE_NEST     = 3'h6;

	// nesting limits
	localparam int TCT_REGION_NEST_MAX = 7;
	localparam int TCT_ELIDE_NEST_MAX  = 1;
	localparam logic [3:0] TCT_DEPTH_ZERO = 4'h0;
	localparam logic [3:0] TCT_DEPTH_ONE  = 4'h1;
endpackage

// >>> tct_tracker.sv
// transactional conflict tracker: read/write line sets, conflict detection,
// abort and commit sequencing with a store buffer held back until commit
// assumes one decoded op per cycle and snoops from the coherence fabric,
// all on i_clk
`timescale 1ns/10ps

// ==========================================================================
// Summary of operation
// - record read and write lines per region
// - flag remote read-write and write-any conflicts
// - match whole lines, not bytes
// - abort discards updates, restores state, exits
// - stores hidden until commit, then drained one per cycle
// - prefix-elided lock only read, never written; inside begin/end a release is buffered as a store
// - abort when tracking capacity exceeded
// - identify and i/o instructions force abort
// - status test reports transactional state
// - explicit abort uses normal abort path
// - accept prefix elision and begin/end entry
// - after abort retry or take lock
// - prefix abort restarts without elision prefix
// - begin/end abort resumes at fallback address
// - nesting seven begin/end, one prefix level
// - write-set eviction forces abort
module tct_tracker #(
	parameter int ADDR_W   = 48,
	parameter int LINE_LSB = 6,  // 64-byte lines
	parameter int ENTRIES  = 16,
	parameter int DATA_W   = 64
) (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// decoded operation from the core
	input  wire logic              i_op_valid,
	input  wire tct_pkg::tct_op_e  i_op,
	input  wire logic [ADDR_W-1:0] i_op_addr,
	input  wire logic [DATA_W-1:0] i_op_data,
	input  wire logic [ADDR_W-1:0] i_op_pc,
	input  wire logic [ADDR_W-1:0] i_fallback_addr,
	// snoops from other logical processors
	input  wire logic              i_snp_valid,
	input  wire logic              i_snp_write,
	input  wire logic [ADDR_W-1:0] i_snp_addr,
	// status and control toward the core
	output logic                   o_in_txn,
	output logic                   o_test_valid,
	output logic                   o_test_result,
	output logic                   o_abort,
	output logic [2:0]             o_abort_cause,
	output logic [ADDR_W-1:0]      o_resume_pc,
	output logic                   o_resume_locked,
	output logic                   o_commit,
	output logic                   o_lock_write_suppress,
	// committed store stream toward memory
	output logic                   o_mem_wr,
	output logic [ADDR_W-1:0]      o_mem_addr,
	output logic [DATA_W-1:0]      o_mem_data
);
	localparam int TAG_W = ADDR_W - LINE_LSB;
	localparam int IDX_W = $clog2(ENTRIES + 1);

	// ======================================================================
	// set storage
	logic [TAG_W-1:0]  tag_ff  [ENTRIES];
	logic [ENTRIES-1:0] rd_ff;
	logic [ENTRIES-1:0] wr_ff;
	logic [ADDR_W-1:0] saddr_ff [ENTRIES];
	logic [DATA_W-1:0] sdata_ff [ENTRIES];
	logic [ENTRIES-1:0] sval_ff;

	tct_pkg::tct_state_e state_ff;
	logic [3:0]          depth_ff;
	logic [ADDR_W-1:0]   fallback_ff;
	logic [ADDR_W-1:0]   acq_pc_ff;
	logic [TAG_W-1:0]    lock_tag_ff;
	logic [IDX_W-1:0]    used_ff;
	logic                draining_ff;
	logic [IDX_W-1:0]    drain_idx_ff;

	// ======================================================================
	// line matching
	logic [TAG_W-1:0]   op_tag;
	logic [TAG_W-1:0]   snp_tag;
	logic [ENTRIES-1:0] op_hit;
	logic [ENTRIES-1:0] snp_hit;
	logic               op_any;
	logic [IDX_W-1:0]   op_idx;
	logic               active;
	logic               tracked_op;

	assign op_tag  = i_op_addr[ADDR_W-1:LINE_LSB];
	assign snp_tag = i_snp_addr[ADDR_W-1:LINE_LSB];
	assign active  = (state_ff != tct_pkg::TCT_ST_IDLE);

	// per-entry tag compare
	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_cmp
			assign op_hit[g]  = (rd_ff[g] | wr_ff[g]) && (tag_ff[g] == op_tag);
			assign snp_hit[g] = (tag_ff[g] == snp_tag) &&
				(wr_ff[g] | (rd_ff[g] & i_snp_write));
		end
	endgenerate

	// hit index encode
	always_comb begin
		op_any = 1'b0;
		op_idx = used_ff;
		for (int k = 0; k < ENTRIES; k++) begin
			if (op_hit[k] && !op_any) begin
				op_any = 1'b1;
				op_idx = IDX_W'(k);
			end
		end
	end

	assign tracked_op = i_op_valid && active &&
		(i_op == tct_pkg::TCT_OP_LOAD || i_op == tct_pkg::TCT_OP_STORE ||
		 i_op == tct_pkg::TCT_OP_ACQ || i_op == tct_pkg::TCT_OP_REL);

	// ======================================================================
	// abort decision, priority: conflict, eviction, forbidden, explicit,
	// capacity, nesting overflow
	logic       nxt_abort;
	logic [2:0] nxt_cause;
	logic       is_store;

	assign is_store = (i_op == tct_pkg::TCT_OP_STORE) ||
		(i_op == tct_pkg::TCT_OP_REL && state_ff != tct_pkg::TCT_ST_ELIDE);

	always_comb begin
		nxt_abort = 1'b0;
		nxt_cause = tct_pkg::TCT_CAUSE_NONE;
		if (active) begin
			if (i_snp_valid && (|snp_hit)) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_CONFLICT;
			end else if (i_op_valid && i_op == tct_pkg::TCT_OP_EVICT && op_any &&
				wr_ff[op_idx[$clog2(ENTRIES)-1:0]]) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_EVICT;
			end else if (i_op_valid && i_op == tct_pkg::TCT_OP_FORBID) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_FORBID;
			end else if (i_op_valid && i_op == tct_pkg::TCT_OP_ABORT) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_EXPLICIT;
			end else if (tracked_op && !op_any && used_ff == IDX_W'(ENTRIES)) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_CAPACITY;
			end else if (i_op_valid && (
				(i_op == tct_pkg::TCT_OP_BEGIN && state_ff == tct_pkg::TCT_ST_REGION &&
				 depth_ff == 4'(tct_pkg::TCT_REGION_NEST_MAX)) ||
				(i_op == tct_pkg::TCT_OP_ACQ && state_ff == tct_pkg::TCT_ST_ELIDE &&
				 depth_ff == 4'(tct_pkg::TCT_ELIDE_NEST_MAX)))) begin
				nxt_abort = 1'b1;
				nxt_cause = tct_pkg::TCT_CAUSE_NEST;
			end
		end
	end

	// ======================================================================
	// region state and nesting depth
	logic end_level;
	assign end_level = i_op_valid && !nxt_abort && (
		(state_ff == tct_pkg::TCT_ST_REGION && i_op == tct_pkg::TCT_OP_END) ||
		(state_ff == tct_pkg::TCT_ST_ELIDE && i_op == tct_pkg::TCT_OP_REL &&
		 op_tag == lock_tag_ff));

	// region entry from idle; a retried acquire after an elided abort takes the lock
	logic start_region;
	assign start_region = i_op_valid && state_ff == tct_pkg::TCT_ST_IDLE && !draining_ff &&
		(i_op == tct_pkg::TCT_OP_BEGIN || (i_op == tct_pkg::TCT_OP_ACQ && !o_resume_locked));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_ff <= tct_pkg::TCT_ST_IDLE;
			depth_ff <= tct_pkg::TCT_DEPTH_ZERO;
		end else if (nxt_abort) begin
			state_ff <= tct_pkg::TCT_ST_IDLE;
			depth_ff <= tct_pkg::TCT_DEPTH_ZERO;
		end else if (start_region) begin
			depth_ff <= tct_pkg::TCT_DEPTH_ONE;
			if (i_op == tct_pkg::TCT_OP_BEGIN) begin
				state_ff <= tct_pkg::TCT_ST_REGION;
			end else begin
				state_ff <= tct_pkg::TCT_ST_ELIDE;
			end
		end else if (i_op_valid && state_ff == tct_pkg::TCT_ST_REGION &&
			i_op == tct_pkg::TCT_OP_BEGIN) begin
			depth_ff <= depth_ff + tct_pkg::TCT_DEPTH_ONE;
		end else if (end_level) begin
			depth_ff <= depth_ff - tct_pkg::TCT_DEPTH_ONE;
			if (depth_ff == tct_pkg::TCT_DEPTH_ONE) begin
				state_ff <= tct_pkg::TCT_ST_IDLE;
			end
		end
	end

	// entry context: fallback address, acquiring pc, lock line
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fallback_ff <= '0;
			acq_pc_ff   <= '0;
			lock_tag_ff <= '0;
		end else if (i_op_valid && state_ff == tct_pkg::TCT_ST_IDLE) begin
			if (i_op == tct_pkg::TCT_OP_BEGIN) begin
				fallback_ff <= i_fallback_addr;
			end else if (i_op == tct_pkg::TCT_OP_ACQ) begin
				acq_pc_ff   <= i_op_pc;
				lock_tag_ff <= op_tag;
			end
		end
	end

	// ======================================================================
	// read/write sets and buffered stores
	logic commit_now;
	assign commit_now = end_level && depth_ff == tct_pkg::TCT_DEPTH_ONE;

	always_ff @(posedge i_clk) begin
		if (i_rst || nxt_abort) begin
			rd_ff   <= '0;
			wr_ff   <= '0;
			sval_ff <= '0;
			used_ff <= '0;
		end else if (commit_now) begin
			rd_ff   <= '0;
			wr_ff   <= '0;
			used_ff <= '0;
		end else if (draining_ff) begin
			sval_ff[drain_idx_ff[$clog2(ENTRIES)-1:0]] <= 1'b0;
		end else if (tracked_op || (start_region && i_op == tct_pkg::TCT_OP_ACQ)) begin
			tag_ff[op_idx[$clog2(ENTRIES)-1:0]] <= op_tag;
			if (!op_any) begin
				used_ff <= used_ff + IDX_W'(1);
			end
			if (is_store) begin
				wr_ff[op_idx[$clog2(ENTRIES)-1:0]]    <= 1'b1;
				sval_ff[op_idx[$clog2(ENTRIES)-1:0]]  <= 1'b1;
				saddr_ff[op_idx[$clog2(ENTRIES)-1:0]] <= i_op_addr;
				sdata_ff[op_idx[$clog2(ENTRIES)-1:0]] <= i_op_data;
			end else begin
				rd_ff[op_idx[$clog2(ENTRIES)-1:0]] <= 1'b1;
			end
		end
	end

	// ======================================================================
	// commit drain: buffered stores leave in entry order after commit, one entry slot per cycle; new
	// regions wait until the drain ends
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			draining_ff  <= 1'b0;
			drain_idx_ff <= '0;
		end else if (commit_now) begin
			draining_ff  <= 1'b1;
			drain_idx_ff <= '0;
		end else if (draining_ff) begin
			drain_idx_ff <= drain_idx_ff + IDX_W'(1);
			if (drain_idx_ff == IDX_W'(ENTRIES - 1)) begin
				draining_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_mem_wr   <= 1'b0;
			o_mem_addr <= '0;
			o_mem_data <= '0;
		end else begin
			o_mem_wr   <= draining_ff && sval_ff[drain_idx_ff[$clog2(ENTRIES)-1:0]];
			o_mem_addr <= saddr_ff[drain_idx_ff[$clog2(ENTRIES)-1:0]];
			o_mem_data <= sdata_ff[drain_idx_ff[$clog2(ENTRIES)-1:0]];
		end
	end

	// ======================================================================
	// status, abort and resume outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_in_txn      <= 1'b0;
			o_test_valid  <= 1'b0;
			o_test_result <= 1'b0;
			o_commit      <= 1'b0;
		end else begin
			o_in_txn      <= (active && !nxt_abort && !commit_now) || start_region;
			o_test_valid  <= i_op_valid && i_op == tct_pkg::TCT_OP_TEST;
			o_test_result <= active;
			o_commit      <= commit_now;
		end
	end

	// lock write of an elided acquire or release is dropped
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_lock_write_suppress <= 1'b0;
		end else begin
			o_lock_write_suppress <= i_op_valid && !nxt_abort && !o_resume_locked &&
				!draining_ff && (i_op == tct_pkg::TCT_OP_ACQ ||
				 (i_op == tct_pkg::TCT_OP_REL && state_ff == tct_pkg::TCT_ST_ELIDE));
		end
	end

	// abort pulse with cause and restart point; resume_locked stays high until
	// the re-executed acquire arrives so the prefix is ignored once
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_abort       <= 1'b0;
			o_abort_cause <= tct_pkg::TCT_CAUSE_NONE;
			o_resume_pc   <= '0;
			o_resume_locked <= 1'b0;
		end else begin
			o_abort <= nxt_abort;
			if (nxt_abort) begin
				o_abort_cause <= nxt_cause;
				if (state_ff == tct_pkg::TCT_ST_ELIDE) begin
					o_resume_pc     <= acq_pc_ff;
					o_resume_locked <= 1'b1;
				end else begin
					o_resume_pc <= fallback_ff;
				end
			end else if (i_op_valid && i_op == tct_pkg::TCT_OP_ACQ) begin
				o_resume_locked <= 1'b0;
			end
		end
	end
endmodule

// >>> tct_tracker_asserts.sv
// port checker for the conflict tracker
// assumes bind onto tct_tracker, one clock, sync reset i_rst
`timescale 1ns/10ps
// ==========================================================================
// checker module
module tct_tracker_asserts (
	// clock and reset
	input wire logic             i_clk,
	input wire logic             i_rst,
	// watched ports
	input wire logic             i_op_valid,
	input wire tct_pkg::tct_op_e i_op,
	input wire logic             i_snp_valid,
	input wire logic             o_in_txn,
	input wire logic             o_test_valid,
	input wire logic             o_test_result,
	input wire logic             o_abort,
	input wire logic [2:0]       o_abort_cause,
	input wire logic             o_resume_locked,
	input wire logic             o_lock_write_suppress,
	input wire logic             o_mem_wr
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// op decodes
	logic is_op;
	assign is_op = i_op_valid && !i_snp_valid;
	chk_test_answer: assert property (i_op_valid && i_op == tct_pkg::TCT_OP_TEST
		|=> o_test_valid && o_test_result == $past(o_in_txn)) else $error("test answer wrong");
	chk_explicit_abort: assert property (is_op && o_in_txn && i_op == tct_pkg::TCT_OP_ABORT
		|=> o_abort && o_abort_cause == tct_pkg::TCT_CAUSE_EXPLICIT) else $error("no abort");
	chk_forbid_abort: assert property (is_op && o_in_txn && i_op == tct_pkg::TCT_OP_FORBID
		|=> o_abort && o_abort_cause == tct_pkg::TCT_CAUSE_FORBID) else $error("no forbid abort");
	chk_abort_exits: assert property (o_abort |-> !o_in_txn) else $error("region kept");
	chk_stores_hidden: assert property (o_in_txn |-> !o_mem_wr) else $error("early store");
	chk_abort_no_wr: assert property (o_abort |-> !o_mem_wr [*2]) else $error("store leak");
	chk_conflict_cause: assert property (o_abort && o_abort_cause == tct_pkg::TCT_CAUSE_CONFLICT
		|-> $past(i_snp_valid)) else $error("conflict without snoop");
	chk_retry_no_elide: assert property (i_op_valid && i_op == tct_pkg::TCT_OP_ACQ
		&& o_resume_locked |=> !o_lock_write_suppress) else $error("retry elided");
endmodule

bind tct_tracker tct_tracker_asserts i_tct_tracker_asserts (.i_clk(i_clk), .i_rst(i_rst),
	.i_op_valid(i_op_valid), .i_op(i_op), .i_snp_valid(i_snp_valid), .o_in_txn(o_in_txn),
	.o_test_valid(o_test_valid), .o_test_result(o_test_result), .o_abort(o_abort),
	.o_abort_cause(o_abort_cause), .o_resume_locked(o_resume_locked),
	.o_lock_write_suppress(o_lock_write_suppress), .o_mem_wr(o_mem_wr));

// >>> tct_remote_cpu.sv
// model of another logical processor issuing coherence snoops
// assumes the bench calls snoop() on i_clk
`timescale 1ns/10ps
// ==========================================================================
// remote snoop source
module tct_remote_cpu #(
	parameter int ADDR_W = 48
) (
	// clock
	input  wire logic         i_clk,
	// snoop stream
	output logic              o_snp_valid,
	output logic              o_snp_write,
	output logic [ADDR_W-1:0] o_snp_addr
);
	// quiet at start
	initial begin
		o_snp_valid = 1'b0;
		o_snp_write = 1'b0;
		o_snp_addr = '0;
	end
	// one remote access after gap cycles; lines invert once released
	task automatic snoop(input logic w, input logic [ADDR_W-1:0] a, input int gap);
		repeat (gap) @(posedge i_clk);
		@(posedge i_clk);
		o_snp_valid <= 1'b1;
		o_snp_write <= w;
		o_snp_addr <= a;
		@(posedge i_clk);
		o_snp_valid <= 1'b0;
		o_snp_write <= ~w;
		o_snp_addr <= ~a;
		#1;
	endtask
endmodule

// >>> transactional_conflict_tracker_tb.sv
// self-checking bench for the conflict tracker
// assumes tct_tracker with ENTRIES=4 and the remote snoop model
`timescale 1ns/10ps
// ==========================================================================
// bench top
module transactional_conflict_tracker_tb;
	localparam int ENT = 4;
	logic i_clk, i_rst, op_valid, snp_valid, snp_write, in_txn, tv, tr, abort, rhle, commit;
	logic sup, mem_wr;
	tct_pkg::tct_op_e op;
	logic [47:0] addr, pc, fb, snp_addr, resume_pc, mem_addr;
	logic [63:0] data, mem_data, wr_xor, wr_axor;
	logic [2:0] cause;
	int n_mismatch, tests_run, n_wr;
	tct_tracker #(.ENTRIES(ENT)) i_tct_tracker (.i_clk(i_clk), .i_rst(i_rst),
		.i_op_valid(op_valid), .i_op(op), .i_op_addr(addr), .i_op_data(data), .i_op_pc(pc),
		.i_fallback_addr(fb), .i_snp_valid(snp_valid), .i_snp_write(snp_write),
		.i_snp_addr(snp_addr), .o_in_txn(in_txn), .o_test_valid(tv), .o_test_result(tr),
		.o_abort(abort), .o_abort_cause(cause), .o_resume_pc(resume_pc),
		.o_commit(commit), .o_lock_write_suppress(sup), .o_mem_wr(mem_wr),
		.o_resume_locked(rhle), .o_mem_addr(mem_addr), .o_mem_data(mem_data));
	tct_remote_cpu i_tct_remote_cpu (.i_clk(i_clk), .o_snp_valid(snp_valid),
		.o_snp_write(snp_write), .o_snp_addr(snp_addr));
	// clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// tally committed stores
	always @(posedge i_clk) begin
		if (mem_wr === 1'b1) begin
			n_wr++;
			wr_xor ^= mem_data;
			wr_axor ^= 64'(mem_addr);
		end
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one op held for one taken edge, outputs settled on return
	task automatic do_op(input tct_pkg::tct_op_e c, input logic [47:0] a, input logic [63:0] d);
		@(posedge i_clk);
		op_valid <= 1'b1;
		op <= c;
		addr <= a;
		data <= d;
		@(posedge i_clk);
		op_valid <= 1'b0;
		#1;
	endtask
	task automatic sc_conflict();
		for (int i = 0; i < 2; i++) begin
			n_wr = 0;
			fb <= 48'h1000 + 48'(i);
			do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
			chk("in_txn", in_txn, 64'h1);
			do_op(i ? tct_pkg::TCT_OP_LOAD : tct_pkg::TCT_OP_STORE, 48'h2040, 64'h55);
			i_tct_remote_cpu.snoop(i[0], 48'h2078, i);
			chk("cause", cause, tct_pkg::TCT_CAUSE_CONFLICT);
			chk("resume_pc", resume_pc, fb);
			chk("in_txn", in_txn, 64'h0);
			repeat (ENT + 4) @(posedge i_clk);
			chk("n_wr", n_wr, 64'h0);
		end
	endtask
	task automatic sc_commit();
		n_wr = 0;
		wr_xor = 64'h0;
		wr_axor = 64'h0;
		do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
		do_op(tct_pkg::TCT_OP_LOAD, 48'h5000, 64'h0);
		do_op(tct_pkg::TCT_OP_STORE, 48'h3000, 64'h11);
		do_op(tct_pkg::TCT_OP_STORE, 48'h3008, 64'h22);
		do_op(tct_pkg::TCT_OP_STORE, 48'h3100, 64'h44);
		do_op(tct_pkg::TCT_OP_TEST, 48'h0, 64'h0);
		chk("test", tr, 64'h1);
		chk("test_valid", tv, 64'h1);
		i_tct_remote_cpu.snoop(1'b0, 48'h5000, 2);
		chk("abort", abort, 64'h0);
		do_op(tct_pkg::TCT_OP_END, 48'h0, 64'h0);
		chk("commit", commit, 64'h1);
		chk("n_wr", n_wr, 64'h0);
		repeat (ENT + 4) @(posedge i_clk);
		chk("n_wr", n_wr, 64'h2);
		chk("wr_xor", wr_xor, 64'h66);
		chk("wr_axor", wr_axor, 64'h108);
		do_op(tct_pkg::TCT_OP_TEST, 48'h0, 64'h0);
		chk("test", tr, 64'h0);
	endtask
	task automatic sc_elide();
		pc <= 48'h700;
		do_op(tct_pkg::TCT_OP_ACQ, 48'h4000, 64'h0);
		chk("suppress", sup, 64'h1);
		i_tct_remote_cpu.snoop(1'b1, 48'h4010, 0);
		chk("resume_pc", resume_pc, 48'h700);
		chk("resume_hle", rhle, 64'h1);
		do_op(tct_pkg::TCT_OP_ACQ, 48'h4000, 64'h0);
		chk("suppress", sup, 64'h0);
		chk("resume_hle", rhle, 64'h0);
		do_op(tct_pkg::TCT_OP_ACQ, 48'h4000, 64'h0);
		do_op(tct_pkg::TCT_OP_REL, 48'h4000, 64'h0);
		chk("commit", commit, 64'h1);
		chk("suppress", sup, 64'h1);
		repeat (ENT + 4) @(posedge i_clk);
	endtask
	task automatic sc_causes();
		tct_pkg::tct_op_e ops[3] = '{tct_pkg::TCT_OP_FORBID, tct_pkg::TCT_OP_ABORT,
			tct_pkg::TCT_OP_EVICT};
		logic [2:0] cs[3] = '{tct_pkg::TCT_CAUSE_FORBID, tct_pkg::TCT_CAUSE_EXPLICIT,
			tct_pkg::TCT_CAUSE_EVICT};
		for (int i = 0; i < 3; i++) begin
			do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
			do_op(tct_pkg::TCT_OP_STORE, 48'h6000, 64'h9);
			do_op(ops[i], 48'h6000, 64'h0);
			chk("cause", cause, cs[i]);
		end
	endtask
	task automatic sc_limits();
		do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
		for (int i = 0; i <= ENT; i++) begin
			do_op(tct_pkg::TCT_OP_LOAD, 48'h8000 + 48'(i * 64), 64'h0);
			chk("cap_abort", abort, 64'(i == ENT));
		end
		for (int i = 0; i < 7; i++) do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
		for (int i = 0; i < 7; i++) begin
			do_op(tct_pkg::TCT_OP_END, 48'h0, 64'h0);
			chk("commit", commit, 64'(i == 6));
		end
		repeat (ENT + 4) @(posedge i_clk);
		for (int i = 0; i < 8; i++) do_op(tct_pkg::TCT_OP_BEGIN, 48'h0, 64'h0);
		chk("cause", cause, tct_pkg::TCT_CAUSE_NEST);
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		i_rst = 1'b1;
		op_valid = 1'b0;
		{addr, pc, fb} = 144'h0;
		{data, wr_xor, wr_axor} = 192'h0;
		op = tct_pkg::TCT_OP_NONE;
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		sc_conflict();
		sc_commit();
		sc_elide();
		sc_causes();
		sc_limits();
		report_and_stop();
	end
	// watchdog: the run needs about two hundred cycles
	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
